// ---- src/dtc_pkg.sv ----
// Package: register map, field layout and types of the dual timer/counter
package dtc_pkg;
   // APB word offsets (byte addresses)
   localparam logic [7:0] DTC_OFF_CTRL    = 8'h00;
   localparam logic [7:0] DTC_OFF_MODE    = 8'h04;
   localparam logic [7:0] DTC_OFF_LOW_0   = 8'h08;
   localparam logic [7:0] DTC_OFF_HIGH_0  = 8'h0c;
   localparam logic [7:0] DTC_OFF_LOW_1   = 8'h10;
   localparam logic [7:0] DTC_OFF_HIGH_1  = 8'h14;
   localparam logic [7:0] DTC_OFF_VECTOR  = 8'h18;
   localparam int         DTC_ADDR_W      = 8;

   // Control register bit positions
   localparam int DTC_CTRL_IRQ_TYPE_0 = 0;
   localparam int DTC_CTRL_IRQ_FLAG_0 = 1;
   localparam int DTC_CTRL_IRQ_TYPE_1 = 2;
   localparam int DTC_CTRL_IRQ_FLAG_1 = 3;
   localparam int DTC_CTRL_RUN_0      = 4;
   localparam int DTC_CTRL_OVF_0      = 5;
   localparam int DTC_CTRL_RUN_1      = 6;
   localparam int DTC_CTRL_OVF_1      = 7;

   // Mode register: counter 0 in low nibble, counter 1 in high nibble
   localparam int DTC_NIB_W        = 4;
   localparam int DTC_MODE_LO_POS  = 0;
   localparam int DTC_MODE_HI_POS  = 1;
   localparam int DTC_SRC_POS      = 2;
   localparam int DTC_GATE_POS     = 3;
   localparam int DTC_NIB_1_BASE   = 4;

   localparam logic [7:0] DTC_CTRL_RESET = 8'h00;
   localparam logic [7:0] DTC_MODE_RESET = 8'h00;
   localparam int         DTC_PRESC_W    = 5;

   typedef enum logic [1:0] {
      DTC_MODE_13BIT,
      DTC_MODE_16BIT,
      DTC_MODE_RELOAD,
      DTC_MODE_SPLIT
   } dtc_mode_t;

   typedef struct packed {
      logic      gate;
      logic      src;
      dtc_mode_t mode;
   } dtc_cfg_t;

   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
   } dtc_count_t;
endpackage

// ---- src/dtc_edge_sync.sv ----
// Three-stage pin synchroniser with falling-edge detect
`timescale 1ns/1ps
module dtc_edge_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic pin_async,
   output logic      level,
   output logic      fall
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else if (ce) begin
         s1_reg <= pin_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Level counts once stages two and three agree
   logic lvl_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_reg <= 1'b1;
      end else if (ce && (s2_reg == s3_reg)) begin
         lvl_reg <= s3_reg;
      end
   end

   assign level = lvl_reg;
   // High sample then low sample
   assign fall  = ce && lvl_reg && (s2_reg == s3_reg) && !s3_reg;
endmodule

// ---- src/dtc_timer.sv ----
// Dual timer/counter with APB register access
`timescale 1ns/1ps

//
// Behaviour
// [RULE1] Counter 0 wrap to zero sets its overflow flag and request.
// [RULE2] Software stops a counter before changing its mode.
// [RULE3] Mode 0: five-bit prescaler in low byte carries into high byte.
// [RULE4] Mode 0 upper three low-byte bits are undefined; software ignores them.
// [RULE5] Mode 1: low and high bytes form one sixteen-bit counter.
// [RULE6] Mode 2: low byte overflow sets flag and reloads from high byte.
// [RULE7] Overflow flag clears when the processor vectors to its routine.
// [RULE8] In reload mode high byte writes only affect the next reload.
// [RULE9] Split mode: counter 0 low byte uses counter 0 controls normally.
// [RULE10] Split mode: counter 0 high byte times, runs on run 1, flags 1.
// [RULE11] Counter 1 in mode 3 halts and holds its count.
// [RULE12] Counter 1 uses upper mode nibble and control bits 2,3,6,7.
// [RULE13] Counter 1 counts on run; with gate also needs pin 1 high.
// [RULE14] Counter 1 wrap to zero sets its overflow flag and request.
// [RULE15] With counter 0 split, counter 1 is run by mode switching; the code holds counter 1 in every mode while counter 0 is split.
// [RULE16] Counter 1 overflow may feed baud rate; reload mode suggested.
// [RULE17] Count pin sampled each cycle; high then low increments.
// [RULE18] Software stops a counter before presetting its count bytes.
// [RULE19] Counter 0 gate and run let pin 0 control counting.
// [RULE20] Gated counting advances only while pin is high and run set.
// [RULE21] Mode bits decode 00 13-bit, 01 16-bit, 10 reload, 11 split.
module dtc_timer
   import dtc_pkg::*;
#(
   parameter int PRESC_W = DTC_PRESC_W
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_pin_0,
   input  wire logic        count_pin_1,
   input  wire logic        ext_irq_pin_0,
   input  wire logic        ext_irq_pin_1,
   input  wire logic        vector_ack_0,
   input  wire logic        vector_ack_1,
   output logic             irq_req_0,
   output logic             irq_req_1,
   output logic             baud_tick
);
   initial begin
      if (PRESC_W < 1 || PRESC_W > 7) begin
         $error("PRESC_W out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin conditioning

   logic [1:0] pin_fall;
   logic [1:0] irq_level;
   logic [1:0] cnt_pins;
   logic [1:0] irq_pins;
   assign cnt_pins = {count_pin_1, count_pin_0};
   assign irq_pins = {ext_irq_pin_1, ext_irq_pin_0};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pins
         // [RULE17] Count pin sampling
         dtc_edge_sync u_cnt (
            .pclk      (pclk),
            .presetn   (presetn),
            .ce        (ce),
            .pin_async (cnt_pins[g]),
            .level     (),
            .fall      (pin_fall[g])
         );
         dtc_edge_sync u_irq (
            .pclk      (pclk),
            .presetn   (presetn),
            .ce        (ce),
            .pin_async (irq_pins[g]),
            .level     (irq_level[g]),
            .fall      ()
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Register decode

   logic [7:0] counter_ctrl_reg;
   logic [7:0] counter_mode_reg;
   dtc_count_t cnt_reg [2];

   logic acc_wr;
   assign acc_wr  = psel && penable && pwrite && ce;
   assign pready  = ce;
   logic addr_ok;
   always_comb begin
      case (paddr)
         DTC_OFF_CTRL, DTC_OFF_MODE, DTC_OFF_LOW_0, DTC_OFF_HIGH_0,
         DTC_OFF_LOW_1, DTC_OFF_HIGH_1, DTC_OFF_VECTOR: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;

   // [RULE12] Counter 1 nibble and bits
   dtc_cfg_t cfg [2];
   assign cfg[0] = counter_mode_reg[DTC_NIB_W-1:0];
   assign cfg[1] = counter_mode_reg[DTC_NIB_1_BASE +: DTC_NIB_W];

   logic run_bit_0;
   logic run_bit_1;
   logic ovf_flag_0;
   logic ovf_flag_1;
   logic gate_sel_0;
   logic gate_sel_1;
   logic src_sel_0;
   logic src_sel_1;
   assign run_bit_0  = counter_ctrl_reg[DTC_CTRL_RUN_0];
   assign run_bit_1  = counter_ctrl_reg[DTC_CTRL_RUN_1];
   assign ovf_flag_0 = counter_ctrl_reg[DTC_CTRL_OVF_0];
   assign ovf_flag_1 = counter_ctrl_reg[DTC_CTRL_OVF_1];
   assign gate_sel_0 = cfg[0].gate;
   assign gate_sel_1 = cfg[1].gate;
   assign src_sel_0  = cfg[0].src;
   assign src_sel_1  = cfg[1].src;

   ////////////////////////////////////////////////////////////////////
   // Count enables

   logic [1:0] run_en;
   logic [1:0] tick;
   logic       split0;
   assign split0 = (cfg[0].mode == DTC_MODE_SPLIT);

   // [RULE19] Gate on pin 0
   // [RULE20] Pin high and run set
   assign run_en[0] = run_bit_0 && (!gate_sel_0 || irq_level[0]);
   // [RULE13] Gate on pin 1
   assign run_en[1] = run_bit_1 && (!gate_sel_1 || irq_level[1]);
   assign tick[0]   = ce && run_en[0] && (src_sel_0 ? pin_fall[0] : 1'b1);
   // [RULE11] Mode 3 halt
   // [RULE15] Split borrows run 1
   assign tick[1]   = ce && (cfg[1].mode != DTC_MODE_SPLIT) && !split0 &&
                      run_en[1] && (src_sel_1 ? pin_fall[1] : 1'b1);
   // [RULE10] High byte timer on run 1
   logic split_hi_tick;
   assign split_hi_tick = ce && split0 && run_bit_1;

   ////////////////////////////////////////////////////////////////////
   // Counter datapath

   localparam logic [PRESC_W-1:0] PRESC_MAX = {PRESC_W{1'b1}};
   dtc_count_t cnt_next [2];
   logic [1:0] wrap;
   logic       split_hi_wrap;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cnt_next[i] = cnt_reg[i];
         wrap[i]     = 1'b0;
         if (tick[i]) begin
            // [RULE21] Mode decode
            case (cfg[i].mode)
               DTC_MODE_13BIT: begin
                  // [RULE3] Prescaler into high byte
                  // [RULE4] Upper low bits left as-is
                  cnt_next[i].low[PRESC_W-1:0] = cnt_reg[i].low[PRESC_W-1:0] + 1'b1;
                  if (cnt_reg[i].low[PRESC_W-1:0] == PRESC_MAX) begin
                     cnt_next[i].high = cnt_reg[i].high + 8'h01;
                     wrap[i] = (cnt_reg[i].high == 8'hff);
                  end
               end
               DTC_MODE_16BIT: begin
                  // [RULE5] Sixteen-bit cascade
                  {cnt_next[i].high, cnt_next[i].low} = {cnt_reg[i].high, cnt_reg[i].low} + 16'h0001;
                  wrap[i] = ({cnt_reg[i].high, cnt_reg[i].low} == 16'hffff);
               end
               DTC_MODE_RELOAD: begin
                  // [RULE6] Reload from high byte
                  // [RULE8] High byte read live at reload
                  if (cnt_reg[i].low == 8'hff) begin
                     cnt_next[i].low = cnt_reg[i].high;
                     wrap[i] = 1'b1;
                  end else begin
                     cnt_next[i].low = cnt_reg[i].low + 8'h01;
                  end
               end
               DTC_MODE_SPLIT: begin
                  // [RULE9] Low byte alone
                  cnt_next[i].low = cnt_reg[i].low + 8'h01;
                  wrap[i] = (cnt_reg[i].low == 8'hff);
               end
               default: begin
                  cnt_next[i] = cnt_reg[i];
               end
            endcase
         end
      end
      split_hi_wrap = 1'b0;
      if (split_hi_tick) begin
         cnt_next[0].high = cnt_reg[0].high + 8'h01;
         split_hi_wrap    = (cnt_reg[0].high == 8'hff);
      end
   end

   // Software writes win over counting; preset with run clear
   generate
      for (g = 0; g < 2; g++) begin : g_cnt
         localparam logic [7:0] OFF_LO = (g == 0) ? DTC_OFF_LOW_0 : DTC_OFF_LOW_1;
         localparam logic [7:0] OFF_HI = (g == 0) ? DTC_OFF_HIGH_0 : DTC_OFF_HIGH_1;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt_reg[g] <= '0;
            end else if (ce) begin
               cnt_reg[g] <= cnt_next[g];
               // [RULE18] Preset only meaningful when stopped
               if (acc_wr && paddr == OFF_LO) begin
                  cnt_reg[g].low <= pwdata[7:0];
               end
               if (acc_wr && paddr == OFF_HI) begin
                  cnt_reg[g].high <= pwdata[7:0];
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Control, mode and flags

   logic [1:0] ovf_set;
   logic [1:0] ovf_clr;
   // [RULE1] Counter 0 wrap
   assign ovf_set[0] = wrap[0];
   // [RULE14] Counter 1 wrap
   assign ovf_set[1] = wrap[1] || split_hi_wrap;
   // [RULE7] Vector acknowledge clears
   assign ovf_clr[0] = vector_ack_0 || (acc_wr && paddr == DTC_OFF_VECTOR && pwdata[0]);
   assign ovf_clr[1] = vector_ack_1 || (acc_wr && paddr == DTC_OFF_VECTOR && pwdata[1]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_ctrl_reg <= DTC_CTRL_RESET;
      end else if (ce) begin
         if (acc_wr && paddr == DTC_OFF_CTRL) begin
            counter_ctrl_reg <= pwdata[7:0];
         end
         if (ovf_clr[0]) begin
            counter_ctrl_reg[DTC_CTRL_OVF_0] <= 1'b0;
         end
         if (ovf_clr[1]) begin
            counter_ctrl_reg[DTC_CTRL_OVF_1] <= 1'b0;
         end
         // Set wins over any clear in the same cycle
         if (ovf_set[0]) begin
            counter_ctrl_reg[DTC_CTRL_OVF_0] <= 1'b1;
         end
         if (ovf_set[1]) begin
            counter_ctrl_reg[DTC_CTRL_OVF_1] <= 1'b1;
         end
      end
   end

   // [RULE2] Mode changes unguarded by design
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_mode_reg <= DTC_MODE_RESET;
      end else if (acc_wr && paddr == DTC_OFF_MODE) begin
         counter_mode_reg <= pwdata[7:0];
      end
   end

   // [RULE16] Baud source from counter 1 wrap
   logic baud_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_reg <= 1'b0;
      end else if (ce) begin
         baud_reg <= wrap[1];
      end
   end
   assign baud_tick = baud_reg;
   assign irq_req_0 = ovf_flag_0;
   assign irq_req_1 = ovf_flag_1;

   ////////////////////////////////////////////////////////////////////
   // Read data

   logic [7:0] rd_byte;
   always_comb begin
      case (paddr)
         DTC_OFF_CTRL:   rd_byte = counter_ctrl_reg;
         DTC_OFF_MODE:   rd_byte = counter_mode_reg;
         DTC_OFF_LOW_0:  rd_byte = cnt_reg[0].low;
         DTC_OFF_HIGH_0: rd_byte = cnt_reg[0].high;
         DTC_OFF_LOW_1:  rd_byte = cnt_reg[1].low;
         DTC_OFF_HIGH_1: rd_byte = cnt_reg[1].high;
         default:        rd_byte = 8'h00;
      endcase
   end

   // Registered so data stays stable across the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end
endmodule

// ---- verif/dtc_timer_asserts.sv ----
// Checker: port-level properties of the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        vector_ack_0,
   input wire logic        vector_ack_1,
   input wire logic        irq_req_0,
   input wire logic        irq_req_1,
   input wire logic        baud_tick
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic unmap;
   logic map;
   logic ctl_wr;
   assign unmap = paddr > 8'h18;
   assign map = (paddr[1:0] == 2'h0) && !unmap;
   // Flags may also be rewritten through the control or vector word
   assign ctl_wr = psel && penable && pwrite && (paddr == 8'h00 || paddr == 8'h18);
   sequence s_acc;
      psel && penable;
   endsequence
   pready_ce_a: assert property (pready == ce) else $error("pready differs from ce");
   err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
   err_unmap_a: assert property (s_acc ##0 unmap |-> pslverr) else $error("no error on unmapped");
   err_map_a: assert property (s_acc ##0 map |-> !pslverr) else $error("error on mapped word");
   rd_unmap_a: assert property (s_acc ##0 (unmap && !pwrite) |-> prdata == 32'h0) else $error("unmapped read");
   rd_upper_a: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
   irq0_fall_a: assert property ($fell(irq_req_0) |-> $past(vector_ack_0) || $past(ctl_wr))
      else $error("flag 0 cleared without cause");
   irq1_fall_a: assert property ($fell(irq_req_1) |-> $past(vector_ack_1) || $past(ctl_wr))
      else $error("flag 1 cleared without cause");
   baud_flag_a: assert property (baud_tick |-> irq_req_1 || $past(vector_ack_1) || $past(ctl_wr))
      else $error("wrap without flag 1");
   freeze_a: assert property (!ce |=> $stable(prdata) && $stable(irq_req_0) && $stable(irq_req_1))
      else $error("state moved while frozen");
endmodule

bind dtc_timer dtc_timer_asserts u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata,
   .pready, .pslverr, .vector_ack_0, .vector_ack_1, .irq_req_0, .irq_req_1, .baud_tick);

// ---- verif/dtc_pin_model.sv ----
// Partner: external count and gate pins
`timescale 1ns/1ps
module dtc_pin_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic fall_req_0,
   input  wire logic fall_req_1,
   input  wire logic gate_0,
   input  wire logic gate_1,
   output logic      count_pin_0,
   output logic      count_pin_1,
   output logic      ext_irq_pin_0,
   output logic      ext_irq_pin_1
);
   logic [2:0] low_0;
   logic [2:0] low_1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_0 <= 3'h0;
         low_1 <= 3'h0;
      end else begin
         low_0 <= fall_req_0 ? 3'h4 : (low_0 != 3'h0 ? low_0 - 3'h1 : 3'h0);
         low_1 <= fall_req_1 ? 3'h4 : (low_1 != 3'h0 ? low_1 - 3'h1 : 3'h0);
      end
   end
   assign count_pin_0 = (low_0 == 3'h0);
   assign count_pin_1 = (low_1 == 3'h0);
   assign ext_irq_pin_0 = gate_0;
   assign ext_irq_pin_1 = gate_1;
endmodule

// ---- verif/test_dtc_timer.sv ----
// Testbench: register-level scenarios for the dual timer/counter
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_dtc_timer import dtc_pkg::*;;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic        pready;
   logic        pslverr;
   logic        cp0;
   logic        cp1;
   logic        gp0;
   logic        gp1;
   logic        irq0;
   logic        irq1;
   logic        baud;
   logic        va0 = 1'b0;
   logic        va1 = 1'b0;
   logic        fr0 = 1'b0;
   logic        fr1 = 1'b0;
   logic        g0 = 1'b1;
   logic        g1 = 1'b1;
   int          err_count = 0;
   int          checks = 0;
   int          cyc = 0;
   int          bauds = 0;

   dtc_timer dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_pin_0(cp0), .count_pin_1(cp1), .ext_irq_pin_0(gp0), .ext_irq_pin_1(gp1),
      .vector_ack_0(va0), .vector_ack_1(va1), .irq_req_0(irq0), .irq_req_1(irq1), .baud_tick(baud));
   dtc_pin_model pins (.pclk(pclk), .presetn(presetn), .fall_req_0(fr0), .fall_req_1(fr1), .gate_0(g0),
      .gate_1(g1), .count_pin_0(cp0), .count_pin_1(cp1), .ext_irq_pin_0(gp0), .ext_irq_pin_1(gp1));

   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (baud === 1'b1)
         bauds++;
      if (cyc == 6000) begin
         err_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Called just after a rising edge; leaves one idle cycle behind
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      xfer(1'b0, a, 8'h00);
      `CHK(r & {24'h0, m}, {24'h0, e})
   endtask
   task automatic fall(input int i, input int n);
      repeat (n) begin
         fr0 <= (i == 0);
         fr1 <= (i == 1);
         @(posedge pclk);
         fr0 <= 1'b0;
         fr1 <= 1'b0;
         repeat (10) @(posedge pclk);
      end
   endtask
   task automatic ack(input int i);
      va0 <= (i == 0);
      va1 <= (i == 1);
      @(posedge pclk);
      va0 <= 1'b0;
      va1 <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic preset(input logic [7:0] m, input logic [7:0] lo_a, input logic [7:0] lo, input logic [7:0] hi);
      wr(DTC_OFF_CTRL, 8'h00);
      wr(DTC_OFF_MODE, m);
      wr(lo_a, lo);
      wr(lo_a + 8'h04, hi);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
         rdc(8'(i * 4), 8'h00);
      wr(8'h1c, 8'hff);
      rdc(8'h1c, 8'h00);
      rdc(DTC_OFF_CTRL, 8'h00);
      // Sixteen-bit wrap, then vectoring clears the flag
      preset(8'h05, DTC_OFF_LOW_0, 8'hff, 8'hff);
      wr(DTC_OFF_CTRL, 8'h10);
      fall(0, 1);
      rdc(DTC_OFF_CTRL, 8'h30);
      `CHK(irq0, 1'b1)
      rdc(DTC_OFF_LOW_0, 8'h00);
      rdc(DTC_OFF_HIGH_0, 8'h00);
      ack(0);
      rdc(DTC_OFF_CTRL, 8'h10);
      // Prescaler carry; upper low-byte bits are not compared
      preset(8'h04, DTC_OFF_LOW_0, 8'hfe, 8'h00);
      wr(DTC_OFF_CTRL, 8'h10);
      fall(0, 2);
      rdc(DTC_OFF_LOW_0, 8'h00, 8'h1f);
      rdc(DTC_OFF_HIGH_0, 8'h01);
      // Auto-reload, reload value changed while running
      preset(8'h06, DTC_OFF_LOW_0, 8'hfe, 8'hf0);
      wr(DTC_OFF_CTRL, 8'h10);
      fall(0, 2);
      rdc(DTC_OFF_LOW_0, 8'hf0);
      rdc(DTC_OFF_CTRL, 8'h30);
      wr(DTC_OFF_VECTOR, 8'h01);
      rdc(DTC_OFF_CTRL, 8'h10);
      wr(DTC_OFF_HIGH_0, 8'h40);
      rdc(DTC_OFF_LOW_0, 8'hf0);
      fall(0, 16);
      rdc(DTC_OFF_LOW_0, 8'h40);
      rdc(DTC_OFF_HIGH_0, 8'h40);
      // Gated counter 0
      preset(8'h0d, DTC_OFF_LOW_0, 8'h00, 8'h00);
      g0 <= 1'b0;
      wr(DTC_OFF_CTRL, 8'h10);
      fall(0, 1);
      rdc(DTC_OFF_LOW_0, 8'h00);
      g0 <= 1'b1;
      repeat (6) @(posedge pclk);
      fall(0, 1);
      rdc(DTC_OFF_LOW_0, 8'h01);
      // Counter 1 on the upper nibble, gated by pin 1
      preset(8'hd0, DTC_OFF_LOW_1, 8'hff, 8'hff);
      g1 <= 1'b0;
      wr(DTC_OFF_CTRL, 8'h40);
      fall(1, 1);
      rdc(DTC_OFF_LOW_1, 8'hff);
      g1 <= 1'b1;
      repeat (6) @(posedge pclk);
      fall(1, 1);
      rdc(DTC_OFF_CTRL, 8'hc0);
      rdc(DTC_OFF_LOW_1, 8'h00);
      `CHK(irq1, 1'b1)
      `CHK(bauds, 1)
      ack(1);
      rdc(DTC_OFF_CTRL, 8'h40);
      // Counter 1 halt mode holds its count
      wr(DTC_OFF_CTRL, 8'h00);
      wr(DTC_OFF_MODE, 8'h70);
      wr(DTC_OFF_CTRL, 8'h40);
      fall(1, 2);
      rdc(DTC_OFF_LOW_1, 8'h00);
      // Split counter 0; counter 1 parked in halt
      preset(8'h77, DTC_OFF_LOW_0, 8'hff, 8'hff);
      wr(DTC_OFF_CTRL, 8'h10);
      fall(0, 1);
      rdc(DTC_OFF_LOW_0, 8'h00);
      rdc(DTC_OFF_CTRL, 8'h30);
      wr(DTC_OFF_CTRL, 8'h40);
      ce <= 1'b0;
      repeat (4) @(posedge pclk);
      ce <= 1'b1;
      @(posedge pclk);
      rdc(DTC_OFF_CTRL, 8'hc0);
      `CHK(irq1, 1'b1)
      wr(DTC_OFF_CTRL, 8'h00);
      rdc(DTC_OFF_LOW_1, 8'h00);
      `CHK(bauds, 1)
      end_of_test();
   end
endmodule
